// >>> core/rfg_ctrl.sv
// receive frame gate and gain test control, AXI4-Lite slave
// assumes header detect, frame end and strength come synchronous to clk
// Notes on behaviour
// R1: frame block set stops new frame starts
// R2: frame in progress finishes despite block
// R3: block works whatever threshold is set
// R4: threshold zero accepts every valid header
// R5: nonzero code needs strength above base plus 3dB(N-1)
// R6: gain fields applied only in measurement mode
// R7: hold select picks manual hold control
// R8: gain reset returns gain to maximum
// R9: loop disable stops automatic gain regulation
// R10: manual gain used only with loop disabled
// R11: reserved bits read zero, ignore writes
module rfg_ctrl
  import rfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hdr_detect,
  input  wire logic        frame_end,
  input  wire logic [7:0]  rx_strength,
  input  wire logic [7:0]  strength_base_level,
  output logic             frame_accept,
  output logic             rx_busy,
  output logic             gain_loop_freeze,
  output logic             gain_reset_max,
  output logic             gain_manual,
  output logic [1:0]       gain_setting
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  gate;
    logic [7:0]  gain;
    logic        meas_en;
    rfg_rx_e     rx;
    logic        accept;
    logic        freeze;
    logic        greset;
    logic        manual;
    logic [1:0]  gset;
    logic [3:0]  thr_code;
    logic        awrdy;
    logic        wrdy;
    logic        arrdy;
    logic        busy;
  } rfg_state_s;

  rfg_state_s st_q;
  rfg_state_s st_d;
  logic [7:0] thr_offset;
  logic [8:0] thr_level;
  logic [7:0] eff_gain;

  rfg_thresh_rom u_rom (
    .clk      (clk),
    .nrst     (nrst),
    .code     (st_q.gate[3:0]),
    .offset_q (thr_offset)
  );

  assign thr_level = {1'b0, strength_base_level} + {1'b0, thr_offset};

  always_comb begin
    st_d = st_q;
    // ****************************************
    // write channel
    // ****************************************
    if (s_axi_awvalid && !st_q.aw_got) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got) begin
      st_d.w_got  = 1'b1;
      st_d.wdata  = s_axi_wdata[7:0];
      st_d.wstrb0 = s_axi_wstrb[0];
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = RFG_AXI_OKAY;
      if (st_q.awaddr[7:2] == RFG_OFS_GATE[7:2]) begin
        if (st_q.wstrb0) st_d.gate = st_q.wdata & RFG_GATE_WMASK; // R11
      end else if (st_q.awaddr[7:2] == RFG_OFS_GAIN_TEST[7:2]) begin
        if (st_q.wstrb0) st_d.gain = st_q.wdata & RFG_GAIN_WMASK; // R6 R11
      end else if (st_q.awaddr[7:2] == RFG_OFS_MEAS_CTRL[7:2]) begin
        if (st_q.wstrb0) st_d.meas_en = st_q.wdata[RFG_BIT_MEAS_EN];
      end else if (st_q.awaddr[7:2] == RFG_OFS_STATUS[7:2]) begin
        st_d.bresp = RFG_AXI_OKAY;
      end else begin
        st_d.bresp = RFG_AXI_SLVERR;
      end
    end
    // ****************************************
    // read channel
    // ****************************************
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RFG_AXI_OKAY;
      st_d.rdata  = 32'h0000_0000;
      if (s_axi_araddr[7:2] == RFG_OFS_GATE[7:2]) begin
        st_d.rdata[7:0] = st_q.gate;
      end else if (s_axi_araddr[7:2] == RFG_OFS_GAIN_TEST[7:2]) begin
        st_d.rdata[7:0] = st_q.gain; // R6
      end else if (s_axi_araddr[7:2] == RFG_OFS_MEAS_CTRL[7:2]) begin
        st_d.rdata[0] = st_q.meas_en;
      end else if (s_axi_araddr[7:2] == RFG_OFS_STATUS[7:2]) begin
        st_d.rdata[1:0] = st_q.rx;
      end else begin
        st_d.rresp = RFG_AXI_SLVERR;
      end
    end
    // ****************************************
    // frame gate
    // ****************************************
    st_d.accept   = 1'b0;
    st_d.thr_code = st_q.gate[3:0];
    case (st_q.rx)
      RFG_IDLE, RFG_BLOCKED: begin
        if (st_q.gate[RFG_BIT_FRAME_BLOCK]) begin
          st_d.rx = RFG_BLOCKED; // R1 R3
        end else begin
          st_d.rx = RFG_IDLE;
          // the table answers a code change one cycle late; a nonzero code accepts nothing until it settles
          if (hdr_detect && (st_q.gate[3:0] == 4'h0 || // R4
              (st_q.thr_code == st_q.gate[3:0] && {1'b0, rx_strength} > thr_level))) begin // R5
            st_d.rx     = RFG_ACTIVE;
            st_d.accept = 1'b1;
          end
        end
      end
      RFG_ACTIVE: begin
        if (frame_end) st_d.rx = RFG_IDLE; // R2
      end
      default: st_d.rx = RFG_IDLE;
    endcase
    // ****************************************
    // gain overrides
    // ****************************************
    eff_gain    = st_q.meas_en ? st_q.gain : RFG_GAIN_RST; // R6
    st_d.freeze = eff_gain[RFG_BIT_HOLD_SEL] & eff_gain[RFG_BIT_HOLD]; // R7
    st_d.greset = eff_gain[RFG_BIT_GAIN_RESET]; // R8
    st_d.manual = eff_gain[RFG_BIT_LOOP_DIS]; // R9
    st_d.gset   = eff_gain[RFG_BIT_LOOP_DIS] ? eff_gain[1:0] : RFG_GAIN_MAX; // R10
    // ****************************************
    // handshake and status flops
    // ****************************************
    st_d.awrdy = !st_d.aw_got;
    st_d.wrdy  = !st_d.w_got;
    st_d.arrdy = !st_d.rvalid;
    st_d.busy  = (st_d.rx == RFG_ACTIVE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{rx: RFG_IDLE, awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready    = st_q.awrdy;
  assign s_axi_wready     = st_q.wrdy;
  assign s_axi_bvalid     = st_q.bvalid;
  assign s_axi_bresp      = st_q.bresp;
  assign s_axi_arready    = st_q.arrdy;
  assign s_axi_rvalid     = st_q.rvalid;
  assign s_axi_rdata      = st_q.rdata;
  assign s_axi_rresp      = st_q.rresp;
  assign frame_accept     = st_q.accept;
  assign rx_busy          = st_q.busy;
  assign gain_loop_freeze = st_q.freeze;
  assign gain_reset_max   = st_q.greset;
  assign gain_manual      = st_q.manual;
  assign gain_setting     = st_q.gset;

  // ****************************************
  // checks
  // ****************************************
  // strength a frame must beat for the programmed nonzero code
  logic [8:0] chk_req;
  assign chk_req = {1'b0, strength_base_level} + 9'(st_q.gate[3:0] - 4'h1) * 9'(RFG_STEP_DB);
  AST_BLOCK_NO_START: assert property (@(posedge clk) disable iff (!nrst) // R1
    (st_q.gate[RFG_BIT_FRAME_BLOCK] && st_q.rx != RFG_ACTIVE) |=> !frame_accept)
    else $error("frame started while blocked");
  AST_ACTIVE_HOLDS: assert property (@(posedge clk) disable iff (!nrst) // R2
    (rx_busy && !frame_end) |=> rx_busy)
    else $error("active frame aborted");
  AST_BLOCK_ANY_THR: assert property (@(posedge clk) disable iff (!nrst) // R3
    (st_q.gate[RFG_BIT_FRAME_BLOCK] && !rx_busy && hdr_detect) |=> !rx_busy)
    else $error("block ignored");
  AST_ZERO_ACCEPTS: assert property (@(posedge clk) disable iff (!nrst) // R4
    (st_q.gate == 8'h00 && st_q.rx == RFG_IDLE && hdr_detect) |=> frame_accept)
    else $error("zero threshold rejected frame");
  AST_WEAK_REJECT: assert property (@(posedge clk) disable iff (!nrst) // R5
    (st_q.gate[3:0] != 4'h0 && {1'b0, rx_strength} <= chk_req) |=> !frame_accept)
    else $error("weak frame accepted");
  AST_MEAS_OFF: assert property (@(posedge clk) disable iff (!nrst) // R6
    !st_q.meas_en |=> !(gain_loop_freeze || gain_reset_max || gain_manual))
    else $error("gain override outside measurement mode");
  AST_HOLD_SEL: assert property (@(posedge clk) disable iff (!nrst) // R7
    (st_q.meas_en && !st_q.gain[RFG_BIT_HOLD_SEL]) |=> !gain_loop_freeze)
    else $error("freeze without hold select");
  AST_GAIN_RESET: assert property (@(posedge clk) disable iff (!nrst) // R8
    (st_q.meas_en && st_q.gain[RFG_BIT_GAIN_RESET]) |=> gain_reset_max)
    else $error("gain reset not applied");
  AST_MANUAL_GAIN: assert property (@(posedge clk) disable iff (!nrst) // R10
    !gain_manual |-> gain_setting == RFG_GAIN_MAX)
    else $error("manual gain without loop disable");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!nrst) // R11
    st_q.gate[6:4] == 3'h0 && st_q.gain[7:6] == 2'h0)
    else $error("reserved bit set");
  AST_STRONG_ACCEPT: assert property (@(posedge clk) disable iff (!nrst) // R5
    (!st_q.gate[RFG_BIT_FRAME_BLOCK] && !rx_busy && hdr_detect && st_q.gate[3:0] != 4'h0 &&
     st_q.thr_code == st_q.gate[3:0] && {1'b0, rx_strength} > chk_req) |=> frame_accept)
    else $error("strong frame refused");
  AST_ZERO_ANY_STATE: assert property (@(posedge clk) disable iff (!nrst) // R4
    (st_q.gate == 8'h00 && !rx_busy && hdr_detect) |=> frame_accept)
    else $error("zero threshold refused frame");
  AST_BLOCK_STATE: assert property (@(posedge clk) disable iff (!nrst) // R1
    (st_q.gate[RFG_BIT_FRAME_BLOCK] && !rx_busy) |=> st_q.rx == RFG_BLOCKED)
    else $error("block bit not honoured");
  AST_BLOCK_RELEASE: assert property (@(posedge clk) disable iff (!nrst) // R1
    (!st_q.gate[RFG_BIT_FRAME_BLOCK] && st_q.rx == RFG_BLOCKED) |=> st_q.rx != RFG_BLOCKED)
    else $error("block kept after clear");
  AST_NO_RESTART: assert property (@(posedge clk) disable iff (!nrst) // R2
    rx_busy |=> !frame_accept)
    else $error("new frame started over active one");
  AST_ACCEPT_BUSY: assert property (@(posedge clk) disable iff (!nrst) // R2
    frame_accept |-> rx_busy)
    else $error("accept without active frame");
  AST_END_CLEARS: assert property (@(posedge clk) disable iff (!nrst) // R2
    (rx_busy && frame_end) |=> !rx_busy)
    else $error("frame end ignored");
  AST_MEAS_OFF_GAIN: assert property (@(posedge clk) disable iff (!nrst) // R6
    !st_q.meas_en |=> gain_setting == RFG_GAIN_MAX)
    else $error("manual gain outside measurement mode");
  AST_HOLD_ON: assert property (@(posedge clk) disable iff (!nrst) // R7
    (st_q.meas_en && st_q.gain[RFG_BIT_HOLD_SEL] && st_q.gain[RFG_BIT_HOLD]) |=> gain_loop_freeze)
    else $error("manual hold not frozen");
  AST_HOLD_OFF: assert property (@(posedge clk) disable iff (!nrst) // R7
    (st_q.meas_en && st_q.gain[RFG_BIT_HOLD_SEL] && !st_q.gain[RFG_BIT_HOLD]) |=> !gain_loop_freeze)
    else $error("manual run still frozen");
  AST_NO_GAIN_RESET: assert property (@(posedge clk) disable iff (!nrst) // R8
    (st_q.meas_en && !st_q.gain[RFG_BIT_GAIN_RESET]) |=> !gain_reset_max)
    else $error("gain reset without bit");
  AST_LOOP_DIS: assert property (@(posedge clk) disable iff (!nrst) // R9
    (st_q.meas_en && st_q.gain[RFG_BIT_LOOP_DIS]) |=> gain_manual)
    else $error("loop disable not applied");
  AST_LOOP_AUTO: assert property (@(posedge clk) disable iff (!nrst) // R9
    (st_q.meas_en && !st_q.gain[RFG_BIT_LOOP_DIS]) |=> !gain_manual)
    else $error("loop stopped without disable");
  AST_MANUAL_SET: assert property (@(posedge clk) disable iff (!nrst) // R10
    (st_q.meas_en && st_q.gain[RFG_BIT_LOOP_DIS]) |=> gain_setting == $past(st_q.gain[1:0]))
    else $error("manual gain code not applied");
  AST_WRITE_GAIN: assert property (@(posedge clk) disable iff (!nrst) // R6
    (st_q.aw_got && st_q.w_got && !st_q.bvalid && st_q.wstrb0 && st_q.awaddr[7:2] == RFG_IDX_GAIN_TEST)
    |=> st_q.gain == {2'b00, $past(st_q.wdata[5:0])})
    else $error("gain test write lost");
  AST_WRITE_GATE: assert property (@(posedge clk) disable iff (!nrst) // R11
    (st_q.aw_got && st_q.w_got && !st_q.bvalid && st_q.wstrb0 && st_q.awaddr[7:2] == RFG_IDX_GATE)
    |=> st_q.gate == {$past(st_q.wdata[7]), 3'h0, $past(st_q.wdata[3:0])})
    else $error("gate write not masked");
  AST_READ_GAIN: assert property (@(posedge clk) disable iff (!nrst) // R6
    (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == RFG_IDX_GAIN_TEST)
    |=> s_axi_rdata == {24'h000000, $past(st_q.gain)})
    else $error("gain test read wrong");
  AST_READ_GATE: assert property (@(posedge clk) disable iff (!nrst) // R11
    (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == RFG_IDX_GATE)
    |=> (s_axi_rdata[31:8] == 24'h000000 && s_axi_rdata[6:4] == 3'h0))
    else $error("gate reserved bits read nonzero");
endmodule

// >>> core/rfg_pkg.sv
// package for the receive frame gate and gain test control block
// assumes an AXI4-Lite slave with 32-bit data and 8-bit register contents
package rfg_pkg;
  // ****************************************
  // register map
  // ****************************************
  // register index; the byte address on the bus is four times the index
  localparam logic [5:0] RFG_IDX_GATE      = 6'h15;
  localparam logic [5:0] RFG_IDX_GAIN_TEST = 6'h3C;
  localparam logic [5:0] RFG_IDX_MEAS_CTRL = 6'h03;
  localparam logic [5:0] RFG_IDX_STATUS    = 6'h11;
  localparam logic [7:0] RFG_OFS_GATE      = {RFG_IDX_GATE, 2'b00};
  localparam logic [7:0] RFG_OFS_GAIN_TEST = {RFG_IDX_GAIN_TEST, 2'b00};
  localparam logic [7:0] RFG_OFS_MEAS_CTRL = {RFG_IDX_MEAS_CTRL, 2'b00};
  localparam logic [7:0] RFG_OFS_STATUS    = {RFG_IDX_STATUS, 2'b00};
  localparam logic [7:0] RFG_GATE_RST      = 8'h00;
  localparam logic [7:0] RFG_GAIN_RST      = 8'h00;
  // ****************************************
  // field layout
  // ****************************************
  localparam int RFG_BIT_FRAME_BLOCK = 7;
  localparam int RFG_BIT_HOLD_SEL    = 5;
  localparam int RFG_BIT_GAIN_RESET  = 4;
  localparam int RFG_BIT_LOOP_DIS    = 3;
  localparam int RFG_BIT_HOLD        = 2;
  localparam int RFG_BIT_MEAS_EN     = 0;
  localparam logic [7:0] RFG_GATE_WMASK = 8'h8F;
  localparam logic [7:0] RFG_GAIN_WMASK = 8'h3F;
  // ****************************************
  // threshold arithmetic, levels in dB steps of the strength input
  // ****************************************
  localparam logic [7:0] RFG_STEP_DB = 8'h03;
  localparam logic [1:0] RFG_GAIN_MAX = 2'h0;
  localparam logic [1:0] RFG_AXI_OKAY   = 2'h0;
  localparam logic [1:0] RFG_AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {RFG_IDLE, RFG_ACTIVE, RFG_BLOCKED} rfg_rx_e;
endpackage

// >>> core/rfg_thresh_rom.sv
// registered threshold table: code to required strength above base
// assumes codes 1..15 need base plus 3 dB times (code minus 1)
module rfg_thresh_rom
  import rfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] code,
  output logic      [7:0] offset_q
);
  logic [7:0] table_w [16];
  // ****************************************
  // table
  // ****************************************
  for (genvar i = 0; i < 16; i++) begin : g_tab
    if (i == 0) begin : g_z
      assign table_w[i] = 8'h00;
    end else begin : g_n
      assign table_w[i] = 8'((i - 1) * RFG_STEP_DB);
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offset_q <= 8'h00;
    end else begin
      offset_q <= table_w[code];
    end
  end
endmodule

// >>> sim/testbench.sv
// testbench for rfg_ctrl: register access over AXI4-Lite, frame gate, gain outputs
// assumes one 50 MHz clock and the register map of rfg_pkg
module testbench
  import rfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, nrst = 1'b0, hdr_detect = 1'b0, frame_end = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_strength = 8'h00, strength_base_level = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   frame_accept, rx_busy, gain_loop_freeze, gain_reset_max, gain_manual;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp, gain_setting;
  wire logic [31:0] s_axi_rdata;
  logic [31:0] seed = 32'h0000_0041;
  int          fail_count = 0, checked = 0, cyc = 0, gate_m = 0, gain_m = 0, meas_m = 0, base, t, lim;
  logic [7:0]  gv [6] = '{8'h3F, 8'h2E, 8'h15, 8'h0A, 8'h21, 8'h00};

  rfg_ctrl dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hdr_detect, .frame_end,
    .rx_strength, .strength_base_level, .frame_accept, .rx_busy, .gain_loop_freeze, .gain_reset_max,
    .gain_manual, .gain_setting);

  always #10 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task wrap_up();
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask

  // gain outputs against the model once settled
  task gchk();
    logic [4:0] e;
    e = meas_m ? {gain_m[5] & gain_m[2], gain_m[4], gain_m[3], gain_m[3] ? gain_m[1:0] : 2'h0} : 5'h00;
    repeat (2) @(posedge clk);
    #1 chk({gain_loop_freeze, gain_reset_max, gain_manual, gain_setting}, e);
  endtask

  // header request; accept pulses counted over three cycles
  task fstart(input logic [7:0] s);
    int p, e;
    p = 0;
    e = !gate_m[7] && (gate_m[3:0] == 0 || s > base + 3 * (gate_m[3:0] - 1));
    @(posedge clk);
    rx_strength <= s;
    hdr_detect <= 1'b1;
    @(posedge clk);
    hdr_detect <= 1'b0;
    repeat (3) begin
      #1 p += (frame_accept === 1'b1);
      @(posedge clk);
    end
    #1 chk(p, e);
    chk(rx_busy, e);
  endtask

  task fstop();
    @(posedge clk);
    frame_end <= 1'b1;
    @(posedge clk);
    frame_end <= 1'b0;
    @(posedge clk);
    #1 chk(rx_busy, 0);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    base = 10 + rnd() % 80;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    strength_base_level <= base[7:0];
    rd(RFG_OFS_GATE, 0, RFG_AXI_OKAY);
    rd(RFG_OFS_GAIN_TEST, 0, RFG_AXI_OKAY);
    wr(RFG_OFS_GATE, 8'hFF, RFG_AXI_OKAY);
    rd(RFG_OFS_GATE, 8'h8F, RFG_AXI_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(RFG_OFS_GATE, 8'h00, RFG_AXI_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(RFG_OFS_GATE, 8'h8F, RFG_AXI_OKAY);
    wr(8'h80, 8'hFF, RFG_AXI_SLVERR);
    rd(8'h80, 0, RFG_AXI_SLVERR);
    wr(RFG_OFS_GAIN_TEST, 8'hFF, RFG_AXI_OKAY);
    gain_m = 8'h3F;
    rd(RFG_OFS_GAIN_TEST, 8'h3F, RFG_AXI_OKAY);
    gchk();
    wr(RFG_OFS_MEAS_CTRL, 8'h01, RFG_AXI_OKAY);
    rd(RFG_OFS_MEAS_CTRL, 32'h0000_0001, RFG_AXI_OKAY);
    meas_m = 1;
    foreach (gv[i]) begin
      wr(RFG_OFS_GAIN_TEST, gv[i], RFG_AXI_OKAY);
      gain_m = gv[i];
      gchk();
    end
    wr(RFG_OFS_GAIN_TEST, 8'h3B, RFG_AXI_OKAY);
    gain_m = 8'h3B;
    wr(RFG_OFS_MEAS_CTRL, 8'h00, RFG_AXI_OKAY);
    meas_m = 0;
    gchk();
    for (t = 0; t < 16; t++) begin
      wr(RFG_OFS_GATE, t[7:0], RFG_AXI_OKAY);
      gate_m = t;
      lim = base + 3 * (t - 1);
      fstart(lim[7:0]);
      fstop();
      fstart(lim[7:0] + 8'h01);
      fstop();
      fstart(8'(rnd()));
      fstop();
    end
    for (t = 0; t < 16; t += 15) begin
      wr(RFG_OFS_GATE, 8'h80 | t[7:0], RFG_AXI_OKAY);
      gate_m = 8'h80 | t;
      fstart(8'hFF);
    end
    wr(RFG_OFS_GATE, 8'h00, RFG_AXI_OKAY);
    gate_m = 0;
    fstart(8'hFF);
    wr(RFG_OFS_GATE, 8'h80, RFG_AXI_OKAY);
    gate_m = 8'h80;
    chk(rx_busy, 1);
    rd(RFG_OFS_STATUS, 32'(RFG_ACTIVE), RFG_AXI_OKAY);
    fstop();
    rd(RFG_OFS_STATUS, 32'(RFG_BLOCKED), RFG_AXI_OKAY);
    fstart(8'hFF);
    wrap_up();
  end
endmodule
